// file: hdl/flash_guard.sv
// Write-protection logic of a serial flash: frame checking, enable latch,
// region guard, pin guard, one-time area and address decode.
// Assumes serial pins asynchronous to i_clk and much slower than it.
`timescale 1ns/10ps
`default_nettype none
module flash_guard #(
  parameter logic [7:0] OP_OTP_IN = 8'h70, // Arbitrary value
  parameter logic [7:0] OP_OTP_OUT = 8'h71, // Arbitrary value
  parameter logic [7:0] OP_LOCKREG = 8'h72 // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Serial pins
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_io0,
  input wire logic i_guard_pin_io2,
  // Mode and stored locks
  input wire logic i_quad_mode,
  input wire logic i_factory_lock_nv,
  input wire logic i_customer_lock_nv,
  // Command results
  output logic o_exec,
  output logic o_refuse,
  output flash_guard_pkg::cmd_type o_cmd,
  output logic [4:0] o_block,
  output logic [3:0] o_sector,
  // Protection state
  output flash_guard_pkg::status_type o_status,
  output logic o_security_bit0
);
  import flash_guard_pkg::*;

  logic [1:0] rst_sync; // Reset release chain
  logic rst_b; // Synchronised reset
  logic [1:0] sclk_sync, cs_sync, io0_sync, wp_sync; // Pin chains
  logic sclk_q, cs_q; // Previous samples
  logic sclk_rise, cs_rise, cs_fall; // Pin edges
  state_type state; // Frame state
  logic [2:0] bit_cnt; // Bits in current byte
  logic [2:0] byte_cnt; // Whole bytes, saturating
  logic [7:0] shift; // Byte being shifted in
  logic [7:0] op; // First byte
  logic [7:0] sdata; // Second byte
  logic [ADDR_W-1:0] addr; // Address bytes
  logic [7:0] next_byte; // Byte with new bit
  status_type st; // Protection state
  logic lock_loaded; // Stored locks captured
  kind_type kind; // Decoded first byte
  logic need_unlock, len_ok, prot, blocked, frame_end, exec, clr_latch;
  logic pin_guard; // Status bits shielded
  logic [4:0] blk; // Addressed block

  // Reset release chain
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_b = rst_sync[1];

  // Two-stage pin synchronisers
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_sync <= 2'h0;
      cs_sync <= 2'h3;
      io0_sync <= 2'h0;
      wp_sync <= 2'h3;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], i_sclk};
      cs_sync <= {cs_sync[0], i_cs_b};
      io0_sync <= {io0_sync[0], i_io0};
      wp_sync <= {wp_sync[0], i_guard_pin_io2};
      sclk_q <= sclk_sync[1];
      cs_q <= cs_sync[1];
    end
  end
  assign sclk_rise = sclk_sync[1] & ~sclk_q & ~cs_sync[1];
  assign cs_rise = cs_sync[1] & ~cs_q;
  assign cs_fall = ~cs_sync[1] & cs_q;
  assign next_byte = {shift[6:0], io0_sync[1]};
  assign frame_end = (state == ST_SHIFT) && cs_rise;

  // Frame state
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= ST_STANDBY;
    else
      case (state)
        ST_STANDBY: if (cs_fall) state <= ST_SHIFT;
        ST_SHIFT: if (cs_rise) state <= ST_STANDBY;
        default: state <= ST_STANDBY;
      endcase
  end

  // Bit and byte gathering
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shift <= 8'h00;
      op <= 8'h00;
      sdata <= 8'h00;
      addr <= '0;
    end
    else if (cs_fall)
    begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end
    else if (sclk_rise && state == ST_SHIFT)
    begin
      shift <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        // Byte complete
        if (byte_cnt != 3'h7)
          byte_cnt <= byte_cnt + 3'h1;
        if (byte_cnt == 3'h0)
          op <= next_byte;
        if (byte_cnt == 3'h1)
          sdata <= next_byte;
        if (byte_cnt >= 3'h1 && byte_cnt <= 3'h3)
          addr <= {addr[ADDR_W-9:0], next_byte};
      end
    end
  end

  // Opcode decode and length checking
  always_comb
  begin
    case (op)
      OP_WRITE_UNLOCK: kind = K_UNLOCK;
      OP_WRITE_LOCK: kind = K_LOCK;
      OP_STATUS_WRITE: kind = K_STATUS;
      OP_PAGE_PROGRAM: kind = K_PROGRAM;
      OP_QUAD_PROGRAM: kind = K_QUAD;
      OP_SECTOR_WIPE: kind = K_SECTOR;
      OP_BLOCK_WIPE: kind = K_BLOCK;
      OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: kind = K_CHIP;
      OP_SLEEP: kind = K_SLEEP;
      OP_WAKE: kind = K_WAKE;
      OP_OTP_IN: kind = K_OTP_IN;
      OP_OTP_OUT: kind = K_OTP_OUT;
      OP_LOCKREG: kind = K_LOCKREG;
      default: kind = K_NONE;
    endcase
    // Whole bytes only; exact count per kind, a minimum count for program and wake
    case (kind)
      K_STATUS: len_ok = byte_cnt == LEN_STATUS;
      K_PROGRAM, K_QUAD: len_ok = byte_cnt >= LEN_PROGRAM;
      K_SECTOR, K_BLOCK: len_ok = byte_cnt == LEN_ADDR;
      K_WAKE: len_ok = byte_cnt >= LEN_SINGLE;
      K_NONE: len_ok = 1'b0;
      default: len_ok = byte_cnt == LEN_SINGLE;
    endcase
    len_ok = len_ok && bit_cnt == 3'h0;
    need_unlock = kind inside {K_STATUS, K_PROGRAM, K_QUAD, K_SECTOR, K_BLOCK,
                            K_CHIP, K_LOCKREG};
  end

  // Region guard lookup
  assign blk = addr[ADDR_W-1:BLOCK_LSB];
  always_comb
  begin
    case (st.guard)
      4'h0: prot = 1'b0;
      4'h1: prot = blk >= 5'h1f;
      4'h2: prot = blk >= 5'h1e;
      4'h3: prot = blk >= 5'h1c;
      4'h4: prot = blk >= 5'h18;
      4'h5: prot = blk >= 5'h10;
      4'ha: prot = blk < 5'h10;
      4'hb: prot = blk < 5'h18;
      4'hc: prot = blk < 5'h1c;
      4'hd: prot = blk < 5'h1e;
      4'he: prot = blk < 5'h1f;
      default: prot = 1'b1;
    endcase
  end

  // Shielding of status bits by the guard pin
  assign pin_guard = st.lockout && !wp_sync[1] && !i_quad_mode;

  // Refusal causes beyond length and latch
  always_comb
  begin
    blocked = 1'b0;
    case (kind)
      K_STATUS: blocked = pin_guard;
      K_PROGRAM, K_QUAD:
        if (st.otp_mode)
          blocked = st.customer_lock || (st.factory_lock &&
                    addr[8:0] < OTP_CUST_START) || addr[8:0] > OTP_TOP;
        else
          blocked = prot;
      K_SECTOR, K_BLOCK: blocked = st.otp_mode || prot;
      K_CHIP: blocked = st.otp_mode || st.guard != GUARD_RST;
      K_LOCKREG: blocked = st.customer_lock;
      default: blocked = 1'b0;
    endcase
    exec = frame_end && len_ok && (!st.sleep || kind == K_WAKE)
           && (!need_unlock || st.write_enable_latch) && !blocked;
    clr_latch = frame_end && len_ok && !st.sleep && (need_unlock || kind == K_LOCK);
  end

  // Protection state, updated at frame end and by the stored-lock load after release
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st.guard <= GUARD_RST;
      st.lockout <= LOCKOUT_RST;
      st.write_enable_latch <= 1'b0;
      st.otp_mode <= 1'b0;
      st.sleep <= 1'b0;
      st.factory_lock <= 1'b0;
      st.customer_lock <= 1'b0;
      lock_loaded <= 1'b0;
    end
    else
    begin
      // Stored locks picked up once after release
      if (!lock_loaded)
      begin
        lock_loaded <= 1'b1;
        st.factory_lock <= i_factory_lock_nv;
        st.customer_lock <= i_customer_lock_nv;
      end
      if (clr_latch)
        st.write_enable_latch <= 1'b0;
      if (exec)
        case (kind)
          K_UNLOCK: st.write_enable_latch <= 1'b1;
          K_STATUS:
          begin
            st.guard <= sdata[SR_GUARD_LSB+3:SR_GUARD_LSB];
            st.lockout <= sdata[SR_LOCKOUT_BIT];
          end
          K_SLEEP: st.sleep <= 1'b1;
          K_WAKE: st.sleep <= 1'b0;
          K_OTP_IN: st.otp_mode <= 1'b1;
          K_OTP_OUT: st.otp_mode <= 1'b0;
          K_LOCKREG: st.customer_lock <= 1'b1;
          default: st.sleep <= st.sleep;
        endcase
    end
  end

  // Command result outputs
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_exec <= 1'b0;
      o_refuse <= 1'b0;
      o_cmd <= '0;
    end
    else
    begin
      o_exec <= exec;
      o_refuse <= frame_end && kind != K_NONE && !exec;
      if (exec)
      begin
        o_cmd.kind <= kind;
        o_cmd.otp <= st.otp_mode;
        o_cmd.addr <= addr;
      end
    end
  end
  assign o_block = o_cmd.addr[ADDR_W-1:BLOCK_LSB];
  assign o_sector = o_cmd.addr[BLOCK_LSB-1:SECTOR_LSB];
  assign o_status = st;
  assign o_security_bit0 = st.factory_lock;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_b);

  byte_bound_a: assert property (o_exec |-> $past(bit_cnt) == 3'h0)
    else $error("command taken off byte boundary");
  unlock_first_a: assert property (o_exec && o_cmd.kind inside {K_STATUS, K_PROGRAM, K_QUAD,
    K_SECTOR, K_BLOCK, K_CHIP, K_LOCKREG} |-> $past(st.write_enable_latch))
    else $error("write command without enable latch");
  latch_drop_a: assert property (exec && need_unlock |=> !st.write_enable_latch
    ##1 !o_status.write_enable_latch)
    else $error("enable latch kept after write command");
  sleep_gate_a: assert property (st.sleep && frame_end && kind != K_WAKE |=> !o_exec)
    else $error("command run in deep sleep");
  top_guard_a: assert property (frame_end && kind == K_SECTOR && !st.otp_mode
    && st.guard == 4'h1 && blk == 5'h1f |=> !o_exec && o_refuse)
    else $error("top block wiped under guard");
  bottom_guard_a: assert property (st.guard == 4'ha |-> prot == (blk < 5'h10))
    else $error("bottom guard map wrong");
  pin_guard_a: assert property (frame_end && kind == K_STATUS && pin_guard
    |=> $stable(st.guard) && $stable(st.lockout))
    else $error("guarded status bits changed");
  quad_free_a: assert property (i_quad_mode |-> !pin_guard)
    else $error("pin guard active in four-wire mode");
  lock_keep_a: assert property (st.customer_lock |=> st.customer_lock [*4])
    else $error("customer lock released");
  otp_array_a: assert property (o_exec && o_cmd.otp |-> !(o_cmd.kind inside
    {K_SECTOR, K_BLOCK, K_CHIP}))
    else $error("array wiped in one-time mode");
  commit_end_a: assert property (!$stable(st.guard) |-> $past(frame_end))
    else $error("guard changed outside frame end");
  standby_rst_a: assert property ($rose(lock_loaded) |-> state == ST_STANDBY)
    else $error("not in standby after reset");
endmodule
`default_nettype wire

// file: pkg/flash_guard_pkg.sv
// Constants and types of the serial flash write-protection block.
// Assumes one system clock; serial pins are sampled, not used as clocks.
`default_nettype none
package flash_guard_pkg;
  // Command opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h38;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hc7;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  // Status byte field positions
  localparam int SR_GUARD_LSB = 2;
  localparam int SR_LOCKOUT_BIT = 7;
  // Reset values
  localparam logic [3:0] GUARD_RST = 4'h0;
  localparam logic LOCKOUT_RST = 1'b0;
  // Address map
  localparam int ADDR_W = 21;
  localparam int BLOCK_LSB = 16;
  localparam int SECTOR_LSB = 12;
  localparam logic [8:0] OTP_CUST_START = 9'h010;
  localparam logic [8:0] OTP_TOP = 9'h1ff;
  // Frame lengths in bytes
  localparam logic [2:0] LEN_SINGLE = 3'h1;
  localparam logic [2:0] LEN_STATUS = 3'h2;
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_PROGRAM = 3'h5;
  // Command kinds
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_UNLOCK = 4'h1, K_LOCK = 4'h2, K_STATUS = 4'h3,
    K_PROGRAM = 4'h4, K_QUAD = 4'h5, K_SECTOR = 4'h6, K_BLOCK = 4'h7,
    K_CHIP = 4'h8, K_SLEEP = 4'h9, K_WAKE = 4'ha, K_OTP_IN = 4'hb,
    K_OTP_OUT = 4'hc, K_LOCKREG = 4'hd
  } kind_type;
  // Frame states
  typedef enum logic {ST_STANDBY = 1'b0, ST_SHIFT = 1'b1} state_type;
  // Executed command
  typedef struct packed {
    kind_type kind;
    logic otp;
    logic [ADDR_W-1:0] addr;
  } cmd_type;
  // Protection state
  typedef struct packed {
    logic [3:0] guard;
    logic lockout;
    logic write_enable_latch;
    logic otp_mode;
    logic sleep;
    logic factory_lock;
    logic customer_lock;
  } status_type;
endpackage
`default_nettype wire

// file: tb/spi_host_model.sv
// Serial host model: one mode 0 frame of up to 40 bits per request.
// Assumes requests only while o_busy is low.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Clock and request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [39:0] i_frame,
  input wire logic [5:0] i_bits,
  // Serial pins
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_io0,
  output logic o_busy
);
  int n; // Bit index
  // Frame engine, sole driver of the pins; clock stands low between frames
  initial
  begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_io0 = 1'b0;
    o_busy = 1'b0;
    forever
    begin
      @(posedge i_clk);
      if (i_go)
      begin
        o_busy <= 1'b1;
        o_cs_b <= 1'b0;
        for (n = 0; n < i_bits; n++)
        begin
          o_io0 <= i_frame[39 - n];
          repeat (4) @(posedge i_clk);
          o_sclk <= 1'b1;
          repeat (4) @(posedge i_clk);
          o_sclk <= 1'b0;
        end
        // Released data line shows no stale bit
        o_io0 <= ~o_io0;
        repeat (4) @(posedge i_clk);
        o_cs_b <= 1'b1;
        repeat (10) @(posedge i_clk);
        o_busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/flash_guard_bench.sv
// Self-checking bench of the flash write-protection block.
// Assumes the serial host model drives the clock, select and data pins; the bench drives the guard pin.
`timescale 1ns/10ps
`default_nettype none
module flash_guard_bench;
  import flash_guard_pkg::*;
  localparam logic [1:0] EXE = 2'h2; // Executed
  localparam logic [1:0] REF = 2'h1; // Refused
  localparam logic [7:0] ENTER = 8'h70; // Arbitrary opcodes
  localparam logic [7:0] LEAVE = 8'h71;
  localparam logic [7:0] LOCKW = 8'h72;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pin = 1'b1; // Guard pin level
  logic quad = 1'b0;
  logic fac_nv = 1'b1; // Stored factory lock
  logic cust_nv = 1'b0; // Stored customer lock
  logic go = 1'b0;
  logic [39:0] frame = 40'h0;
  logic [5:0] nbits = 6'h0;
  logic sclk, cs_b, io0, busy, exec, refuse, sec0;
  cmd_type cmd;
  status_type st;
  logic [4:0] blk;
  logic [3:0] sec;
  logic [1:0] last = 2'h0; // Last result pair
  int npulse = 0;
  int mismatches = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  spi_host_model i_host (.i_clk(clk), .i_go(go), .i_frame(frame), .i_bits(nbits),
    .o_sclk(sclk), .o_cs_b(cs_b), .o_io0(io0), .o_busy(busy));
  flash_guard #(.OP_OTP_IN(ENTER), .OP_OTP_OUT(LEAVE), .OP_LOCKREG(LOCKW)) i_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_io0(io0),
    .i_guard_pin_io2(pin), .i_quad_mode(quad), .i_factory_lock_nv(fac_nv),
    .i_customer_lock_nv(cust_nv), .o_exec(exec), .o_refuse(refuse), .o_cmd(cmd),
    .o_block(blk), .o_sector(sec), .o_status(st), .o_security_bit0(sec0));
  // Record each result pulse
  always @(posedge clk)
    if (exec === 1'b1 || refuse === 1'b1)
    begin
      last <= {exec, refuse};
      npulse <= npulse + 1;
    end
  task automatic chk_pair(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One frame, then judge its outcome
  task automatic send(input logic [39:0] f, input logic [5:0] b, input logic [1:0] exp,
    input string nm);
    int n0;
    int w;
    @(posedge clk);
    n0 = npulse;
    frame <= f;
    nbits <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (w = 0; busy === 1'b1 && w < 3000; w++)
      @(posedge clk);
    chk_pair(nm, exp, (npulse != n0) ? last : 2'h0);
  endtask
  task automatic op1(input logic [7:0] op, input logic [1:0] exp, input string nm);
    send({op, 32'h0}, 6'h08, exp, nm);
  endtask
  task automatic unlock();
    op1(OP_WRITE_UNLOCK, EXE, "unlock");
  endtask
  task automatic wsr(input logic [7:0] sb, input logic [1:0] exp);
    unlock();
    send({OP_STATUS_WRITE, sb, 24'h0}, 6'h10, exp, "status write");
  endtask
  function automatic logic [39:0] af(input logic [7:0] op, input logic [20:0] a);
    af = {op, 3'h0, a, 8'h5a};
  endfunction
  // Protected block per guard code
  function automatic logic prot(input logic [3:0] c, input int b);
    if (c == 4'h0)
      prot = 1'b0;
    else if (c <= 4'h5)
      prot = b >= 32 - (1 << (c - 1));
    else if (c >= 4'ha && c <= 4'he)
      prot = b < 32 - (16 >> (c - 10));
    else
      prot = 1'b1;
  endfunction
  task automatic t_wel();
    logic [7:0] ops [6] = '{OP_WRITE_LOCK, OP_PAGE_PROGRAM, OP_QUAD_PROGRAM,
      OP_BLOCK_WIPE, OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
    logic [5:0] lens [6] = '{6'h08, 6'h28, 6'h28, 6'h20, 6'h08, 6'h08};
    int k;
    send(af(OP_PAGE_PROGRAM, 21'h0), 6'h28, REF, "no latch");
    unlock();
    send(af(OP_SECTOR_WIPE, 21'h0), 6'h21, REF, "odd length");
    send(af(OP_SECTOR_WIPE, 21'h0), 6'h1f, REF, "short");
    chk_val("latch kept", 32'h1, {31'h0, st.write_enable_latch});
    send(af(OP_SECTOR_WIPE, 21'h1fffff), 6'h20, EXE, "top");
    chk_val("block", 32'h1f, {27'h0, blk});
    chk_val("sector", 32'hf, {28'h0, sec});
    chk_val("kind", 32'(K_SECTOR), {28'h0, cmd.kind});
    for (k = 0; k < 6; k++)
    begin
      unlock();
      send(af(ops[k], 21'h0), lens[k], EXE, "clearing op");
      chk_val("latch cleared", 32'h0, {31'h0, st.write_enable_latch});
    end
  endtask
  task automatic t_guard();
    int bl [5] = '{0, 15, 16, 30, 31};
    int c;
    int k;
    for (c = 0; c < 16; c++)
    begin
      wsr({2'h0, c[3:0], 2'h0}, EXE);
      chk_val("guard", 32'(c), {28'h0, st.guard});
      for (k = 0; k < 5; k++)
      begin
        unlock();
        send(af(OP_SECTOR_WIPE, {bl[k][4:0], 16'h0}), 6'h20,
          prot(c[3:0], bl[k]) ? REF : EXE, "wipe");
      end
    end
    wsr(8'h00, EXE);
  endtask
  task automatic t_pin();
    @(posedge clk);
    pin <= 1'b0;
    wsr(8'h04, EXE);
    chk_val("unguarded", 32'h1, {28'h0, st.guard});
    wsr(8'h80, EXE);
    chk_val("lockout", 32'h2, {30'h0, st.lockout, st.write_enable_latch});
    wsr(8'h84, REF);
    chk_val("guard kept", 32'h0, {28'h0, st.guard});
    @(posedge clk);
    quad <= 1'b1;
    wsr(8'h84, EXE);
    @(posedge clk);
    quad <= 1'b0;
    pin <= 1'b1;
    wsr(8'h00, EXE);
  endtask
  task automatic t_sleep();
    op1(OP_SLEEP, EXE, "sleep");
    op1(OP_WRITE_UNLOCK, REF, "asleep");
    op1(OP_WAKE, EXE, "wake");
    chk_val("awake", 32'h0, {30'h0, st.sleep, st.write_enable_latch});
  endtask
  task automatic t_otp();
    op1(ENTER, EXE, "enter");
    unlock();
    send(af(OP_BLOCK_WIPE, 21'h0), 6'h20, REF, "array");
    unlock();
    send(af(OP_PAGE_PROGRAM, 21'h00f), 6'h28, REF, "serial");
    unlock();
    send(af(OP_PAGE_PROGRAM, 21'h010), 6'h28, EXE, "custom");
    chk_val("otp flag", 32'h1, {31'h0, cmd.otp});
    unlock();
    op1(LOCKW, EXE, "lock");
    chk_val("cust lock", 32'h1, {31'h0, st.customer_lock});
    unlock();
    send(af(OP_PAGE_PROGRAM, 21'h1ff), 6'h28, REF, "locked");
    unlock();
    op1(LOCKW, REF, "relock");
    op1(LEAVE, EXE, "leave");
    chk_val("otp mode", 32'h0, {31'h0, st.otp_mode});
  endtask
  // Second reset with other stored locks
  task automatic t_reset();
    @(posedge clk);
    fac_nv <= 1'b0;
    cust_nv <= 1'b1;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk_val("stored locks", 32'h1, {22'h0, st});
    chk_val("sec bit low", 32'h0, {31'h0, sec0});
    unlock();
    op1(LOCKW, REF, "stored lock");
    op1(ENTER, EXE, "enter again");
    unlock();
    send(af(OP_PAGE_PROGRAM, 21'h00f), 6'h28, REF, "cust all");
    op1(LEAVE, EXE, "leave again");
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk_val("status", 32'h2, {22'h0, st});
    chk_val("sec bit", 32'h1, {31'h0, sec0});
    t_wel();
    t_guard();
    t_pin();
    t_sleep();
    t_otp();
    t_reset();
    complete_run();
  end
  // Watchdog
  initial
  begin
    repeat (95000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
